// ### hw/console_pkg.sv
// shared constants and carriers for the operator console block
package console_pkg;
    localparam int WORD_W = 16;
    localparam int BLOCK_WORDS = 4096;
    localparam int MAX_WORDS = 65536;
    localparam int BLOCK_BITS = 4;
    localparam int DEV_W = 6;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    // mode switch codes on the panel
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_STEP = 2'h2;
    localparam logic [1:0] MODE_VAR = 2'h3;
    // register function switch codes
    localparam logic [2:0] SEL_A = 3'h0;
    localparam logic [2:0] SEL_B = 3'h1;
    localparam logic [2:0] SEL_X = 3'h2;
    localparam logic [2:0] SEL_P = 3'h3;
    localparam logic [2:0] SEL_MADDR = 3'h4;
    localparam logic [2:0] SEL_MDATA = 3'h5;
    localparam logic [2:0] SEL_INS1 = 3'h6;
    localparam logic [2:0] SEL_INS2 = 3'h7;
    // bootstrap source device codes
    localparam logic [5:0] DEV_KBD = 6'h02;
    localparam logic [5:0] DEV_CARD = 6'h03;
    localparam logic [5:0] DEV_TAPE = 6'h04;
    localparam logic [5:0] DEV_MAG_FIRST = 6'h0b;
    localparam logic [5:0] DEV_MAG_LAST = 6'h0e;
    typedef enum logic [4:0] {
        B_IDLE = 5'h01,
        B_HIGH = 5'h02,
        B_LOW = 5'h04,
        B_STORE = 5'h08,
        B_DONE = 5'h10
    } boot_e;
    typedef struct packed {
        logic [1:0] mode;
        logic key_normal;
        logic [2:0] reg_sel;
        logic clear_key;
        logic enter_key;
        logic digit_key;
        logic [2:0] digit;
        logic run_key;
        logic boot_key;
    } panel_s;
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] x;
        logic [15:0] p;
    } regs_s;
    localparam panel_s PANEL_RESET = '{mode: MODE_HALT, default: '0};
endpackage : console_pkg

// ### hw/operator_console.sv
// operator console: panel, run control, memory examine and bootstrap
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Operation
// R01 - fetch only in free run with no interrupt or transfer pending
// R02 - memory comes in 4096-word blocks, at most 65536 words
// R03 - unpopulated locations ignore writes and read as zero
// R04 - input from an absent bus device delivers a zero word
// R05 - output to an absent device does nothing; one bus user at a time
// R06 - loader source code: 2 keyboard, 3 cards, 4 tape, 11-14 magtape
// R07 - loader starts the medium except keyboard, skips leading zero bytes
// R08 - two bytes per word, stored from P, stop after zero word, jump to P
// R09 - checksum is the wrapping sum of all stored words
// R10 - start from P, device from X, bias from B
// R11 - selected register shown when halted, stepping or variable speed
// R12 - clear zeroes entry, digits build value, enter loads register
// R13 - register selector ignored while free running
// R14 - console display and change only with key switch at normal
// R15 - halted memory data: bare enter advances address and shows next word
// R16 - halted memory data: keyed enter writes, advances, shows next word
// R17 - first instruction view shows and edits the word at P
// R18 - second instruction view shows and edits the word after P
// R19 - run key in step mode executes one step then returns
// R20 - step and variable speed modes reserve keyset and display
// R21 - call and arm/disarm ops always run the next instruction too
// R22 - console address counter wraps from top back to zero
module operator_console #(
    parameter int MEM_BLOCKS = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input console_pkg::panel_s panel,
    input console_pkg::regs_s cpu_regs,
    input wire logic irq_pending,
    input wire logic dma_pending,
    input wire logic step_done,
    input wire logic step_atomic,
    input wire logic [15:0] mem_rdata,
    input wire logic io_present,
    input wire logic io_byte_valid,
    input wire logic [7:0] io_byte,
    output logic fetch_enable,
    output logic step_go,
    output logic [15:0] display,
    output logic panel_owns_io,
    output logic reg_load,
    output logic [2:0] reg_load_sel,
    output logic [15:0] reg_load_data,
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [5:0] io_dev,
    output logic io_start,
    output logic io_rd,
    output logic boot_busy,
    output logic [15:0] checksum,
    output logic [15:0] boot_bias
);
    console_pkg::panel_s panel_s1;
    console_pkg::panel_s panel_s2;
    console_pkg::panel_s panel_q;
    console_pkg::boot_e boot_state;
    logic [15:0] entry;
    logic keyed;
    logic [15:0] maddr;
    logic [15:0] load_ptr;
    logic [15:0] start_addr;
    logic [7:0] high_byte;
    logic [15:0] boot_word;
    logic seen_nonzero;
    logic rd_hit;
    logic [15:0] rd_word;
    logic [15:0] view_word;
    logic clear_edge;
    logic enter_edge;
    logic digit_edge;
    logic run_edge;
    logic boot_edge;
    logic is_run;
    logic is_halt;
    logic is_step;
    logic console_on;
    logic [15:0] view_addr;
    logic [7:0] rx_byte;
    logic con_write;
    logic [15:0] con_addr;

    // memory is decoded per 4096-word block; the top nibble picks the block
    function automatic logic populated(input logic [15:0] addr);
        populated = {1'b0, addr[15:12]} < 5'(MEM_BLOCKS); // R02
    endfunction : populated

    // two flops on every panel pin before anything looks at it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            panel_s1 <= console_pkg::PANEL_RESET;
            panel_s2 <= console_pkg::PANEL_RESET;
            panel_q <= console_pkg::PANEL_RESET;
        end
        else
        begin
            panel_s1 <= panel;
            panel_s2 <= panel_s1;
            panel_q <= panel_s2;
        end
    end

    // key edges and mode decode, all from the second stage onward
    assign clear_edge = panel_s2.clear_key & ~panel_q.clear_key;
    assign enter_edge = panel_s2.enter_key & ~panel_q.enter_key;
    assign digit_edge = panel_s2.digit_key & ~panel_q.digit_key;
    assign run_edge = panel_s2.run_key & ~panel_q.run_key;
    assign boot_edge = panel_s2.boot_key & ~panel_q.boot_key;
    assign is_run = panel_s2.mode == console_pkg::MODE_RUN;
    assign is_halt = panel_s2.mode == console_pkg::MODE_HALT;
    assign is_step = panel_s2.mode == console_pkg::MODE_STEP;
    // selector dead in free run and with key switch off normal
    assign console_on = panel_s2.key_normal & ~is_run & ~boot_busy; // R13 R14

    // memory views: data at maddr, instruction word at P or after P
    always_comb
    begin
        unique case (panel_s2.reg_sel)
            console_pkg::SEL_INS1: view_addr = cpu_regs.p; // R17
            console_pkg::SEL_INS2:
                view_addr = cpu_regs.p + console_pkg::ADDR_ONE; // R18
            default: view_addr = maddr;
        endcase
    end

    // unpopulated read data is forced to zero rather than trusted
    assign rd_word = rd_hit ? mem_rdata : console_pkg::WORD_ZERO; // R03
    // an absent device answers with zeros
    assign rx_byte = io_present ? io_byte : 8'h00; // R04
    assign boot_word = {high_byte, rx_byte}; // R08

    // keyed console write: memory data in halt, instruction views in halt or step
    always_comb
    begin
        con_write = 1'b0;
        con_addr = view_addr;
        if (console_on && enter_edge && keyed)
        begin
            if (panel_s2.reg_sel == console_pkg::SEL_MDATA)
                con_write = is_halt; // R16
            else if (panel_s2.reg_sel == console_pkg::SEL_INS1 ||
                     panel_s2.reg_sel == console_pkg::SEL_INS2)
                con_write = is_halt | is_step; // R17 R18
        end
    end

    // entry value: clear zeroes it, each octal digit shifts in
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            entry <= console_pkg::WORD_ZERO;
            keyed <= 1'b0;
        end
        else if (console_on && clear_edge)
        begin
            entry <= console_pkg::WORD_ZERO; // R12
            keyed <= 1'b1;
        end
        else if (console_on && digit_edge)
        begin
            entry <= {entry[12:0], panel_s2.digit}; // R12
            keyed <= 1'b1;
        end
        else if (console_on && enter_edge)
            keyed <= 1'b0;
    end

    // console address counter; plain 16-bit add wraps at the top
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            maddr <= console_pkg::WORD_ZERO;
        else if (console_on && enter_edge)
        begin
            if (panel_s2.reg_sel == console_pkg::SEL_MADDR && keyed)
                maddr <= entry;
            else if (panel_s2.reg_sel == console_pkg::SEL_MDATA && is_halt)
                maddr <= maddr + console_pkg::ADDR_ONE; // R15 R16 R22
        end
    end

    // register loads come from the enter key or the end of a bootstrap
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_load <= 1'b0;
            reg_load_sel <= console_pkg::SEL_A;
            reg_load_data <= console_pkg::WORD_ZERO;
        end
        else if (boot_state == console_pkg::B_DONE)
        begin
            reg_load <= 1'b1; // R08
            reg_load_sel <= console_pkg::SEL_P;
            reg_load_data <= start_addr;
        end
        else
        begin
            reg_load <= console_on && enter_edge && keyed &&
                panel_s2.reg_sel < console_pkg::SEL_MADDR; // R12
            reg_load_sel <= panel_s2.reg_sel;
            reg_load_data <= entry;
        end
    end

    // one memory port: loader store wins, then console write, then refresh
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= console_pkg::WORD_ZERO;
            mem_wdata <= console_pkg::WORD_ZERO;
            rd_hit <= 1'b0;
        end
        else
        begin
            rd_hit <= mem_rd && populated(mem_addr); // R03
            if (boot_state == console_pkg::B_STORE)
            begin
                mem_rd <= 1'b0;
                mem_wr <= populated(load_ptr); // R03
                mem_addr <= load_ptr;
                mem_wdata <= boot_word;
            end
            else if (con_write)
            begin
                mem_rd <= 1'b0;
                mem_wr <= populated(con_addr); // R03
                mem_addr <= con_addr;
                mem_wdata <= entry;
            end
            else
            begin
                // free reads keep the memory views current
                mem_rd <= ~boot_busy;
                mem_wr <= 1'b0;
                mem_addr <= view_addr;
            end
        end
    end

    // latest word seen through the memory views
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            view_word <= console_pkg::WORD_ZERO;
        else
            view_word <= rd_word; // R03
    end

    // display follows the selector outside free run with key at normal and no bootstrap busy; blank otherwise
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            display <= console_pkg::WORD_ZERO;
        else if (!console_on)
            display <= console_pkg::WORD_ZERO; // R13 R14
        else
        begin
            unique case (panel_s2.reg_sel)
                console_pkg::SEL_A: display <= cpu_regs.a; // R11
                console_pkg::SEL_B: display <= cpu_regs.b;
                console_pkg::SEL_X: display <= cpu_regs.x;
                console_pkg::SEL_P: display <= cpu_regs.p;
                console_pkg::SEL_MADDR: display <= maddr;
                default: display <= view_word; // R15 R17 R18
            endcase
        end
    end

    // run control: call and arm/disarm ops hold the fetch open once more
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fetch_enable <= 1'b0;
            step_go <= 1'b0;
            panel_owns_io <= 1'b0;
        end
        else
        begin
            fetch_enable <= ~boot_busy & (step_atomic |
                (is_run & ~irq_pending & ~dma_pending)); // R01 R21
            step_go <= (is_step && panel_s2.key_normal && run_edge) ||
                (step_done && step_atomic); // R19 R21
            panel_owns_io <= is_step |
                (panel_s2.mode == console_pkg::MODE_VAR); // R20
        end
    end

    // bootstrap loader state
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            boot_state <= console_pkg::B_IDLE;
            boot_busy <= 1'b0;
            io_dev <= console_pkg::DEV_KBD;
            io_start <= 1'b0;
            io_rd <= 1'b0;
            load_ptr <= console_pkg::WORD_ZERO;
            start_addr <= console_pkg::WORD_ZERO;
            boot_bias <= console_pkg::WORD_ZERO;
            checksum <= console_pkg::WORD_ZERO;
            high_byte <= 8'h00;
            seen_nonzero <= 1'b0;
        end
        else
        begin
            io_start <= 1'b0;
            unique case (boot_state)
                console_pkg::B_IDLE:
                    if (boot_edge && is_halt && panel_s2.key_normal)
                    begin
                        load_ptr <= cpu_regs.p; // R10
                        start_addr <= cpu_regs.p;
                        io_dev <= cpu_regs.x[5:0]; // R06 R10
                        boot_bias <= cpu_regs.b; // R10
                        checksum <= console_pkg::WORD_ZERO;
                        seen_nonzero <= 1'b0;
                        boot_busy <= 1'b1;
                        io_rd <= 1'b1;
                        // keyboard needs no start; absent device gets none
                        io_start <= io_present &&
                            cpu_regs.x[5:0] != console_pkg::DEV_KBD; // R05 R07
                        boot_state <= console_pkg::B_HIGH;
                    end
                console_pkg::B_HIGH:
                    if (io_byte_valid)
                    begin
                        if (seen_nonzero || rx_byte != 8'h00) // R07
                        begin
                            high_byte <= rx_byte;
                            seen_nonzero <= 1'b1;
                            boot_state <= console_pkg::B_LOW;
                        end
                    end
                console_pkg::B_LOW:
                    if (io_byte_valid)
                        boot_state <= console_pkg::B_STORE; // R08
                console_pkg::B_STORE:
                begin
                    checksum <= checksum + boot_word; // R09
                    load_ptr <= load_ptr + console_pkg::ADDR_ONE;
                    if (boot_word == console_pkg::WORD_ZERO)
                    begin
                        io_rd <= 1'b0;
                        boot_state <= console_pkg::B_DONE; // R08
                    end
                    else
                        boot_state <= console_pkg::B_HIGH;
                end
                console_pkg::B_DONE:
                begin
                    boot_busy <= 1'b0;
                    boot_state <= console_pkg::B_IDLE;
                end
                default: boot_state <= console_pkg::B_IDLE;
            endcase
        end
    end

    // rule checks on the system clock
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_unpop_no_write: assert property (mem_wr |-> populated(mem_addr)) // R03
        else $error("write to unpopulated memory");
    a_unpop_read_zero: assert property (
        mem_rd && !populated(mem_addr) |=> rd_word == 16'h0000) // R03
        else $error("unpopulated read not zero");
    a_fetch_gate_cause: assert property (
        !step_atomic && !is_run |=> !fetch_enable) // R01
        else $error("fetch enabled outside free run");
    a_run_selector_dead: assert property (
        is_run && enter_edge && boot_state == console_pkg::B_IDLE
        |=> !reg_load && !mem_wr) // R13
        else $error("console acted in free run");
    a_key_normal_only: assert property (
        !panel_s2.key_normal && enter_edge && !boot_busy
        |=> !reg_load && !mem_wr) // R14
        else $error("console acted off normal");
    a_addr_wrap_top: assert property (
        console_on && is_halt && enter_edge &&
        panel_s2.reg_sel == console_pkg::SEL_MDATA && maddr == 16'hffff
        |=> maddr == 16'h0000) // R22
        else $error("address did not wrap");
    a_kbd_no_start: assert property (
        io_start |-> io_dev != console_pkg::DEV_KBD && io_present) // R07
        else $error("start sent to keyboard or absent device");
    a_checksum_sum: assert property (
        boot_state == console_pkg::B_STORE
        |=> checksum == $past(checksum) + $past(boot_word)) // R09
        else $error("checksum not updated by stored word");
    a_zero_word_stop: assert property (
        boot_state == console_pkg::B_STORE && boot_word == 16'h0000
        |=> boot_state == console_pkg::B_DONE ##1 reg_load &&
        reg_load_sel == console_pkg::SEL_P) // R08
        else $error("loader did not stop and jump on zero word");
    a_step_one_pulse: assert property (
        is_step && panel_s2.key_normal && run_edge && !step_done
        |=> step_go ##1 !step_go) // R19
        else $error("step pulse wrong");

    c_boot_done: cover property (boot_state == console_pkg::B_DONE);
    c_mem_deposit: cover property (con_write && is_halt);
    c_atomic_step: cover property (step_done && step_atomic ##1 step_go);
    c_reg_enter: cover property (reg_load && !boot_busy);
endmodule : operator_console

// ### dv/console_partner.sv
// far-side model: memory array and bootstrap byte source
`timescale 1ns/1ps
module console_partner (
    input wire logic clock,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    input wire logic io_rd,
    output logic io_byte_valid,
    output logic [7:0] io_byte
);
    logic [15:0] mem [int];
    logic [7:0] q [$];
    int gap = 0;
    logic hold = 1'b0;

    // unwritten words read as a pattern so a missing zero fill shows up
    function automatic logic [15:0] mval(input logic [15:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : a ^ 16'ha5a5;
    endfunction : mval

    initial
    begin
        mem_rdata = 16'h0000;
        io_byte = 8'h00;
        io_byte_valid = 1'b0;
    end

    // data stands only the cycle after the read strobe, junk otherwise
    always @(posedge clock)
    begin
        if (mem_wr)
            mem[int'(mem_addr)] = mem_wdata;
        mem_rdata <= mem_rd ? mval(mem_addr) : ~mem_rdata;
    end

    // one byte per slot at random spacing; held one more cycle for the store
    always @(posedge clock)
    begin
        io_byte_valid <= 1'b0;
        if (io_rd && q.size() > 0 && gap == 0)
        begin
            io_byte <= q.pop_front();
            io_byte_valid <= 1'b1;
            hold <= 1'b1;
            gap <= 2 + $urandom_range(0, 3);
        end
        else
        begin
            gap <= (gap > 0) ? gap - 1 : 0;
            hold <= 1'b0;
            if (!hold)
                io_byte <= ~io_byte; // released line shows no stale byte
        end
    end
endmodule : console_partner

// ### dv/tb_top.sv
// self-checking bench for the operator console
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
    end end
module tb_top;
    localparam int K_BOOT = 0;
    localparam int K_RUN = 1;
    localparam int K_DIG = 2;
    localparam int K_ENT = 3;
    localparam int K_CLR = 4;
    logic clock, resetn, irq_pending, dma_pending, step_done, step_atomic;
    console_pkg::panel_s panel;
    console_pkg::regs_s cpu_regs;
    logic fetch_enable, step_go, panel_owns_io, reg_load, mem_rd, mem_wr;
    logic io_start, io_rd, boot_busy, io_byte_valid, io_present;
    logic [2:0] reg_load_sel, last_sel;
    logic [15:0] display, reg_load_data, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] checksum, boot_bias, last_data;
    logic [7:0] io_byte;
    logic [5:0] io_dev;
    logic [5:0] codes [7] = '{6'h02, 6'h03, 6'h04, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
    int error_cnt = 0, cmp_count = 0, n_load = 0, n_wr = 0, n_go = 0;
    int n_start = 0;

    // top block left empty
    operator_console #(.MEM_BLOCKS(15)) u_operator_console (
        .clock(clock), .resetn(resetn), .panel(panel), .cpu_regs(cpu_regs),
        .irq_pending(irq_pending), .dma_pending(dma_pending),
        .step_done(step_done), .step_atomic(step_atomic),
        .mem_rdata(mem_rdata), .io_present(io_present),
        .io_byte_valid(io_byte_valid), .io_byte(io_byte),
        .fetch_enable(fetch_enable), .step_go(step_go), .display(display),
        .panel_owns_io(panel_owns_io), .reg_load(reg_load),
        .reg_load_sel(reg_load_sel), .reg_load_data(reg_load_data),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .io_dev(io_dev), .io_start(io_start),
        .io_rd(io_rd), .boot_busy(boot_busy), .checksum(checksum),
        .boot_bias(boot_bias));

    console_partner u_console_partner (
        .clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .io_rd(io_rd), .io_byte_valid(io_byte_valid), .io_byte(io_byte));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // pulse counters, so checks need not land on the exact cycle
    always @(posedge clock)
    begin
        if (reg_load)
        begin
            n_load++;
            last_sel = reg_load_sel;
            last_data = reg_load_data;
        end
        n_wr += mem_wr;
        n_go += step_go;
        n_start += io_start;
    end

    function automatic logic [15:0] regval(input int s);
        return cpu_regs[63 - 16 * s -: 16];
    endfunction : regval

    function automatic logic fetch_exp();
        return step_atomic | (panel.mode == console_pkg::MODE_RUN
            & !irq_pending & !dma_pending);
    endfunction : fetch_exp

    // key held past the two-flop sync, then low long enough to re-arm
    task automatic press(input int k);
        {panel.clear_key, panel.enter_key, panel.digit_key, panel.run_key,
            panel.boot_key} <= 5'h01 << k;
        repeat (4) @(posedge clock);
        {panel.clear_key, panel.enter_key, panel.digit_key, panel.run_key,
            panel.boot_key} <= 5'h00;
        repeat (6) @(posedge clock);
    endtask : press

    task automatic key_val(input logic [15:0] v);
        logic [17:0] w;
        w = {2'b00, v};
        press(K_CLR);
        for (int i = 5; i >= 0; i--)
        begin
            panel.digit <= w[3 * i +: 3];
            @(posedge clock);
            press(K_DIG);
        end
        press(K_ENT);
    endtask : key_val

    task automatic select(input logic [2:0] s);
        panel.reg_sel <= s;
        repeat (8) @(posedge clock);
    endtask : select

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        summarize();
    end

    initial
    begin
        logic [15:0] v, sum, bias, st;
        logic [15:0] w [3];
        int k;
        panel = console_pkg::PANEL_RESET;
        panel.key_normal = 1'b1;
        cpu_regs = '0;
        {io_present, irq_pending, dma_pending, step_done, step_atomic} = 5'h10;
        resetn = 1'b0;
        void'($urandom(5861));
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        cpu_regs <= {$urandom, $urandom};
        repeat (4) @(posedge clock);
        for (int s = 0; s < 4; s++)
        begin
            v = 16'($urandom);
            select(3'(s));
            `CHK(display, regval(s))
            key_val(v);
            `CHK({last_sel, last_data}, {3'(s), v})
        end
        press(K_CLR);
        press(K_ENT);
        `CHK({n_load, last_data}, {32'd5, 16'h0000})
        panel.mode <= console_pkg::MODE_RUN;
        select(console_pkg::SEL_B);
        `CHK(display, 16'h0000)
        key_val(16'h0777);
        `CHK(n_load, 5)
        panel.mode <= console_pkg::MODE_HALT;
        panel.key_normal <= 1'b0;
        select(console_pkg::SEL_X);
        `CHK(display, 16'h0000)
        key_val(16'h0777);
        `CHK(n_load, 5)
        panel.key_normal <= 1'b1;
        $display("test registers done");
        select(console_pkg::SEL_MADDR);
        key_val(16'hfffe);
        select(console_pkg::SEL_MDATA);
        `CHK(display, 16'h0000)
        press(K_ENT);
        `CHK(display, 16'h0000)
        k = n_wr;
        key_val(16'h1234);
        `CHK(n_wr, k)
        `CHK(display, u_console_partner.mval(16'h0000))
        v = 16'($urandom);
        key_val(v);
        `CHK(u_console_partner.mval(16'h0000), v)
        `CHK(display, u_console_partner.mval(16'h0001))
        press(K_ENT);
        `CHK(display, u_console_partner.mval(16'h0002))
        select(console_pkg::SEL_MADDR);
        `CHK(display, 16'h0002)
        $display("test memory done");
        cpu_regs.p <= 16'h0010;
        panel.mode <= console_pkg::MODE_STEP;
        select(console_pkg::SEL_INS1);
        `CHK(panel_owns_io, 1'b1)
        `CHK(display, u_console_partner.mval(16'h0010))
        v = 16'($urandom);
        key_val(v);
        `CHK(u_console_partner.mval(16'h0010), v)
        select(console_pkg::SEL_INS2);
        `CHK(display, u_console_partner.mval(16'h0011))
        k = n_go;
        press(K_RUN);
        `CHK(n_go, k + 1)
        step_atomic <= 1'b1;
        step_done <= 1'b1;
        @(posedge clock);
        step_done <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK(n_go, k + 2)
        $display("test step done");
        for (int i = 0; i < 24; i++)
        begin
            panel.mode <= 2'($urandom);
            {irq_pending, dma_pending} <= 2'($urandom);
            step_atomic <= ($urandom_range(0, 3) == 0);
            repeat (6) @(posedge clock);
            `CHK(fetch_enable, fetch_exp())
            `CHK(panel_owns_io, panel.mode[1])
        end
        panel.mode <= console_pkg::MODE_HALT;
        {irq_pending, dma_pending, step_atomic} <= 3'h0;
        $display("test fetch done");
        foreach (codes[j])
        begin
            st = 16'h0100 + 16'(j) * 16'h0020;
            bias = 16'($urandom);
            sum = 16'h0000;
            cpu_regs <= '{a: 16'h0000, b: bias, x: {10'h000, codes[j]}, p: st};
            k = n_start;
            u_console_partner.q = '{8'h00, 8'h00};
            for (int i = 0; i < 3; i++)
            begin
                w[i] = (16'($urandom) | 16'h0100) & ((i == 1) ? 16'hff00 : 16'hffff);
                u_console_partner.q.push_back(w[i][15:8]);
                u_console_partner.q.push_back(w[i][7:0]);
                sum += w[i];
            end
            u_console_partner.q.push_back(8'h00);
            u_console_partner.q.push_back(8'h00);
            repeat (2) @(posedge clock);
            press(K_BOOT);
            `CHK(io_dev, codes[j])
            `CHK(boot_bias, bias)
            for (int i = 0; i < 300 && boot_busy !== 1'b0; i++)
                @(posedge clock);
            `CHK(boot_busy, 1'b0)
            repeat (2) @(posedge clock);
            `CHK(n_start, k + int'(codes[j] != 6'h02))
            for (int i = 0; i < 3; i++)
                `CHK(u_console_partner.mval(st + 16'(i)), w[i])
            `CHK(u_console_partner.mval(st + 16'h0003), 16'h0000)
            `CHK(checksum, sum)
            `CHK({last_sel, last_data}, {3'h3, st})
        end
        io_present <= 1'b0;
        k = n_start + n_wr;
        u_console_partner.q = '{8'h12, 8'h34};
        press(K_BOOT);
        repeat (20) @(posedge clock);
        `CHK({boot_busy, n_start + n_wr}, {1'b1, k})
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK({boot_busy, io_rd}, 2'h0)
        $display("test bootstrap done");
        summarize();
    end
endmodule : tb_top
